// ### shared/srpsw_pkg.sv
// Purpose: constants shared by the waveform generator files
// Assumes: one 16-bit base timer, eight channels, byte-addressed register map
// Notes: all offsets are Wishbone byte addresses
package srpsw_pkg;
    // ==========================================================
    // sizes
    localparam int NCH = 8;
    localparam int TW = 16;
    // ==========================================================
    // register byte offsets
    localparam logic [7:0] ADR_BTC = 8'h00;
    localparam logic [7:0] ADR_FEN = 8'h04;
    localparam logic [7:0] ADR_FSEL = 8'h08;
    localparam logic [7:0] ADR_PSC = 8'h0C;
    localparam logic [7:0] ADR_CNT = 8'h10;
    localparam logic [7:0] ADR_FLAG = 8'h14;
    localparam logic [7:0] ADR_PIN = 8'h18;
    localparam logic [7:0] ADR_OCTL = 8'h20;
    localparam logic [7:0] ADR_CMP = 8'h40;
    // ==========================================================
    // field positions
    localparam int BTC_BIT9_RESET_OPTION = 3;
    localparam int BTC_IT = 4;
    localparam int OCTL_IVL = 3;
    localparam int OCTL_INV = 4;
    localparam int PSC_RNG_LSB = 1;
    localparam int PSC_DIV_LSB = 8;
    localparam int FLAG_OVF = 8;
    // ==========================================================
    // codes and values after reset
    localparam logic [2:0] MODE_SINGLE = 3'h0;
    localparam logic [2:0] MODE_TOGGLE = 3'h1;
    localparam logic [2:0] MODE_SR = 3'h2;
    localparam logic [2:0] RST_FREE = 3'h0;
    localparam logic [2:0] RST_CMP0 = 3'h2;
    localparam logic [4:0] BTC_RESET = 5'h00;
    localparam logic [4:0] OCTL_RESET = 5'h00;
    localparam logic [15:0] CMP_RESET = 16'h0000;
    localparam logic [7:0] DIV_RESET = 8'h00;
    localparam logic [7:0] DIV_LOWEST = 8'hFF;
    localparam logic [15:0] TMR_ZERO = 16'h0000;
    localparam logic [15:0] TMR_TOP = 16'hFFFF;
    localparam logic [9:0] BIT9_WRAP = 10'h3FF;
    localparam logic [3:0] PHASE_BASE_LAST = 4'h4;
endpackage

// ### shared/srpsw_tmr_if.sv
// Purpose: base timer view handed from the top to each channel
// Assumes: single clock domain
// Notes: src drives, snk only reads
`timescale 1ns/1ns
interface srpsw_tmr_if;
    logic [15:0] count;
    logic zero_hit;
    logic sr_block01;
    modport src(output count, output zero_hit, output sr_block01);
    modport snk(input count, input zero_hit, input sr_block01);
endinterface

// ### rtl/srpsw_chan.sv
// Purpose: one waveform channel, level generator and registered pin
// Assumes: compare events are evaluated on the current timer value
// Notes: set event wins over every clear event in the same cycle
`timescale 1ns/1ns
module srpsw_chan #(
    parameter int CH_ID = 0
) (
    input wire logic clk_i,
    input wire logic rst_i,
    srpsw_tmr_if.snk tmr,
    input wire logic active_i,
    input wire logic [2:0] mode_i,
    input wire logic ivl_i,
    input wire logic inv_i,
    input wire logic [15:0] cmp_i,
    input wire logic partner_match_i,
    input wire logic phase_part_i,
    input wire logic phase_step_i,
    output logic match_o,
    output logic pin_o
);
    // ==========================================================
    // level generator
    logic lvl;
    logic next_lvl;
    logic sr_ok;

    assign match_o = (tmr.count == cmp_i);
    // only even channels, and not 0/1 while channel 0 resets the timer
    assign sr_ok = (CH_ID % 2 == 0) && !(CH_ID < 2 && tmr.sr_block01); // [RULE_06] [RULE_22]

    // next level; phase steps replace the zero event of single mode
    always_comb begin
        next_lvl = lvl;
        if (!active_i) begin
            next_lvl = ivl_i; // [RULE_03] [RULE_07]
        end else if (phase_part_i) begin
            // relies on single mode, low start and inversion set up [RULE_10]
            if (match_o) begin
                next_lvl = 1'b1;
            end else if (phase_step_i) begin
                next_lvl = 1'b0; // [RULE_13]
            end
        end else begin
            case (mode_i)
                srpsw_pkg::MODE_SINGLE: begin
                    if (match_o) begin
                        next_lvl = 1'b1; // [RULE_21]
                    end else if (tmr.zero_hit) begin
                        next_lvl = 1'b0; // [RULE_11]
                    end
                end
                srpsw_pkg::MODE_TOGGLE: begin
                    if (match_o) begin
                        next_lvl = ~lvl;
                    end
                end
                srpsw_pkg::MODE_SR: begin
                    if (sr_ok && match_o) begin
                        next_lvl = 1'b1; // [RULE_01] [RULE_05]
                    end else if (sr_ok && (partner_match_i || tmr.zero_hit)) begin
                        next_lvl = 1'b0; // [RULE_02] [RULE_23]
                    end
                end
                default: next_lvl = lvl;
            endcase
        end
    end

    // level and pin registers; a stopped channel drives low
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            lvl <= 1'b0;
            pin_o <= 1'b0;
        end else begin
            lvl <= next_lvl;
            pin_o <= active_i ? (next_lvl ^ inv_i) : 1'b0; // [RULE_04] [RULE_07]
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_sr_set: assert property (active_i && !phase_part_i && mode_i == srpsw_pkg::MODE_SR // [RULE_01]
        && sr_ok && match_o |=> pin_o == !$past(inv_i)) else $error("sr set missed");
    chk_sr_clear: assert property (active_i && !phase_part_i // [RULE_02]
        && mode_i == srpsw_pkg::MODE_SR && sr_ok && !match_o
        && (partner_match_i || tmr.zero_hit) |=> pin_o == $past(inv_i))
        else $error("sr clear missed");
    chk_stop_low: assert property (!active_i |=> !pin_o) else $error("stopped pin not low"); // [RULE_07]
    chk_start_lvl: assert property ($rose(active_i) |-> lvl == $past(ivl_i)) // [RULE_03]
        else $error("start level wrong");
    chk_phase_rise: assert property (active_i && phase_part_i && phase_step_i // [RULE_13]
        && !match_o |=> pin_o == $past(inv_i)) else $error("phase step ignored");
endmodule // srpsw_chan

// ### rtl/srpsw_phase.sv
// Purpose: phase shift clock divider and channel step sequencer
// Assumes: reload pulse is the base timer overflow request
// Notes: steps are one-cycle pulses, one channel per divided clock
`timescale 1ns/1ns
module srpsw_phase (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic enable_i,
    input wire logic reload_i,
    input wire logic [7:0] divisor_i,
    input wire logic [1:0] range_i,
    output logic [7:0] step_o,
    output logic [7:0] part_o
);
    // ==========================================================
    // divider and sequencer
    logic [7:0] cnt;
    logic [3:0] idx;
    logic [3:0] last;
    logic kill7;

    assign last = srpsw_pkg::PHASE_BASE_LAST + {2'b00, range_i}; // [RULE_17]
    // slowest clock with all eight channels never reaches channel 7
    assign kill7 = (range_i == 2'b11) && (divisor_i == srpsw_pkg::DIV_LOWEST); // [RULE_15]

    // divide by divisor plus one, reloaded on each timer overflow
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt <= srpsw_pkg::DIV_RESET;
            idx <= 4'h0;
            step_o <= 8'h00;
        end else begin
            step_o <= 8'h00;
            if (reload_i) begin
                cnt <= divisor_i; // [RULE_14]
                idx <= 4'h0;
            end else if (enable_i) begin
                if (cnt == 8'h00) begin
                    cnt <= divisor_i; // [RULE_12]
                    if (idx <= last) begin
                        idx <= idx + 4'h1;
                        if (!(idx == 4'h7 && kill7)) begin
                            step_o[idx[2:0]] <= 1'b1; // [RULE_13]
                        end
                    end
                end else begin
                    cnt <= cnt - 8'h01;
                end
            end
        end
    end

    // channels taking part in phase shifting
    for (genvar k = 0; k < srpsw_pkg::NCH; k++) begin : g_part
        always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
                part_o[k] <= 1'b0;
            end else begin
                part_o[k] <= enable_i && (4'(k) <= last); // [RULE_17]
            end
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_no_step7: assert property (kill7 |=> !step_o[7]) else $error("channel 7 stepped"); // [RULE_15]
    chk_reload_seq: assert property (reload_i |=> idx == 4'h0 && cnt == $past(divisor_i)) // [RULE_14]
        else $error("reload failed");
    chk_div_period: assert property (enable_i && !reload_i && cnt == 8'h00 // [RULE_12]
        |=> cnt == $past(divisor_i)) else $error("divider reload wrong");
endmodule // srpsw_phase

// ### rtl/srpsw_top.sv
// Purpose: set/reset and phase shift waveform generator with Wishbone registers
// Assumes: timer counts up once per SYS_CLK_I, the timer count clock
// Notes: Wishbone classic slave, ack one cycle after the request, writes on the ack edge
// Operation
// [RULE_01] even channel output goes high when timer equals its compare value
// [RULE_02] even output goes low on odd partner match or timer zero
// [RULE_03] initial-level bit set makes the waveform start high
// [RULE_04] invert bit set drives the inverse of the generated level
// [RULE_05] free timer: high width n-m, or 65536-m when m not below n
// [RULE_06] timer reset by channel 0 match disables set/reset on channels 0, 1
// [RULE_07] function enable starts the channel output, clearing it stops output
// [RULE_08] each channel match sets its own sticky match flag; the code sets it only while the channel is active
// [RULE_09] software clears the function-select bit to choose waveform generation
// [RULE_10] software sets single mode, low start, bit-9 reset, invert before phase shift
// [RULE_11] inverted single mode: pin low on match, high at timer zero
// [RULE_12] phase clock is the count clock divided by divisor plus one
// [RULE_13] each phase clock pulse raises the next channel output from channel 0
// [RULE_14] timer overflow request reloads divider and restarts the step sequence
// [RULE_15] all channels at slowest phase clock: channel 7 gets no step
// [RULE_16] software parks a pin on the port to hold it low
// [RULE_17] phase enable bit and pin range field, code 00 covers channels 0-4
// [RULE_18] bit-9 reset option clears the timer when bit 9 overflows
// [RULE_19] interrupt-select 0 raises overflow request on bit 15 or bit 9 overflow
// [RULE_20] three-bit mode field selects the waveform mode of each channel
// [RULE_21] single mode: high on match, low when timer reaches zero
// [RULE_22] set/reset mode has its own mode code, even channels only
// [RULE_23] odd partner pin is untouched, its match only clears the even output
`timescale 1ns/1ns
module srpsw_top (
    input wire logic SYS_CLK_I,
    input wire logic SYS_RST_I,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    output logic [7:0] WAVEFORM_PIN_O,
    output logic [7:0] WAVEFORM_OE_O
);
    // ==========================================================
    // declarations
    logic [15:0] count;
    logic [15:0] next_count;
    logic ovf_pulse;
    logic ovf_evt;
    logic wrap9;
    logic cmp0_hit;
    logic [2:0] timer_reset_select;
    logic bit9_reset_option;
    logic overflow_irq_select;
    logic [7:0] function_enable_reg;
    logic [7:0] function_select_reg;
    logic phase_shift_enable;
    logic [1:0] phase_pin_range;
    logic [7:0] phase_divisor;
    logic [4:0] output_control [srpsw_pkg::NCH];
    logic [15:0] compare_value [srpsw_pkg::NCH];
    logic [8:0] match_irq_flag;
    logic [8:0] flag_set;
    logic [8:0] flag_clr;
    logic [7:0] match;
    logic [7:0] step;
    logic [7:0] part;
    logic [7:0] active;
    logic req;
    logic wr_go;
    logic [31:0] rdat;

    srpsw_tmr_if tmr();

    // merge write data into an old value under the byte enables
    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return res;
    endfunction

    // ==========================================================
    // base timer
    assign wrap9 = (count[9:0] == srpsw_pkg::BIT9_WRAP);
    assign cmp0_hit = (timer_reset_select == srpsw_pkg::RST_CMP0)
        && (count == 16'(compare_value[0] + 16'h0001));
    // bit 9 overflow counts as a request only while the select bit is clear
    assign ovf_evt = (count == srpsw_pkg::TMR_TOP) || (wrap9 && !overflow_irq_select); // [RULE_19]

    // next timer value, channel 0 reset first, then the bit-9 option
    always_comb begin
        if (cmp0_hit) begin
            next_count = srpsw_pkg::TMR_ZERO;
        end else if (bit9_reset_option && wrap9) begin
            next_count = srpsw_pkg::TMR_ZERO; // [RULE_18]
        end else begin
            next_count = count + 16'h0001;
        end
    end

    // timer and overflow request; the request lines up with count bits 9:0 at zero
    always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            count <= srpsw_pkg::TMR_ZERO;
            ovf_pulse <= 1'b0;
        end else begin
            count <= next_count;
            ovf_pulse <= ovf_evt; // [RULE_19]
        end
    end

    assign tmr.count = count;
    assign tmr.zero_hit = (count == srpsw_pkg::TMR_ZERO);
    assign tmr.sr_block01 = (timer_reset_select == srpsw_pkg::RST_CMP0); // [RULE_06]

    // ==========================================================
    // Wishbone slave
    assign req = WB_CYC_I && WB_STB_I;
    assign wr_go = req && WB_WE_I && WB_ACK_O;

    // ack one cycle after the request, dropped the cycle after
    always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h0000_0000;
        end else begin
            WB_ACK_O <= req && !WB_ACK_O;
            if (req && !WB_ACK_O) begin
                WB_DAT_O <= rdat;
            end
        end
    end

    // read decode; unmapped addresses read zero
    always_comb begin
        if (WB_ADR_I == srpsw_pkg::ADR_BTC) begin
            rdat = 32'({overflow_irq_select, bit9_reset_option, timer_reset_select});
        end else if (WB_ADR_I == srpsw_pkg::ADR_FEN) begin
            rdat = 32'(function_enable_reg);
        end else if (WB_ADR_I == srpsw_pkg::ADR_FSEL) begin
            rdat = 32'(function_select_reg);
        end else if (WB_ADR_I == srpsw_pkg::ADR_PSC) begin
            rdat = 32'({phase_divisor, 5'h00, phase_pin_range, phase_shift_enable});
        end else if (WB_ADR_I == srpsw_pkg::ADR_CNT) begin
            rdat = 32'(count);
        end else if (WB_ADR_I == srpsw_pkg::ADR_FLAG) begin
            rdat = 32'(match_irq_flag);
        end else if (WB_ADR_I == srpsw_pkg::ADR_PIN) begin
            rdat = 32'(WAVEFORM_PIN_O);
        end else if (WB_ADR_I[7:5] == srpsw_pkg::ADR_OCTL[7:5] && WB_ADR_I[1:0] == 2'b00) begin
            rdat = 32'(output_control[WB_ADR_I[4:2]]);
        end else if (WB_ADR_I[7:5] == srpsw_pkg::ADR_CMP[7:5] && WB_ADR_I[1:0] == 2'b00) begin
            rdat = 32'(compare_value[WB_ADR_I[4:2]]);
        end else begin
            rdat = 32'h0000_0000;
        end
    end

    // timer, enable, select and phase shift controls
    always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            {overflow_irq_select, bit9_reset_option, timer_reset_select} <= srpsw_pkg::BTC_RESET;
            function_enable_reg <= 8'h00;
            function_select_reg <= 8'h00;
            phase_shift_enable <= 1'b0;
            phase_pin_range <= 2'b00;
            phase_divisor <= srpsw_pkg::DIV_RESET;
        end else if (wr_go) begin
            if (WB_ADR_I == srpsw_pkg::ADR_BTC) begin
                {overflow_irq_select, bit9_reset_option, timer_reset_select} <= 5'(wmerge(
                    32'({overflow_irq_select, bit9_reset_option, timer_reset_select}),
                    WB_DAT_I, WB_SEL_I));
            end else if (WB_ADR_I == srpsw_pkg::ADR_FEN) begin
                function_enable_reg <= 8'(wmerge(32'(function_enable_reg), WB_DAT_I, WB_SEL_I));
            end else if (WB_ADR_I == srpsw_pkg::ADR_FSEL) begin
                function_select_reg <= 8'(wmerge(32'(function_select_reg), WB_DAT_I, WB_SEL_I));
            end else if (WB_ADR_I == srpsw_pkg::ADR_PSC) begin
                if (WB_SEL_I[0]) begin
                    phase_shift_enable <= WB_DAT_I[0]; // [RULE_17]
                    phase_pin_range <= WB_DAT_I[srpsw_pkg::PSC_RNG_LSB +: 2];
                end
                if (WB_SEL_I[1]) begin
                    phase_divisor <= WB_DAT_I[srpsw_pkg::PSC_DIV_LSB +: 8];
                end
            end
        end
    end

    // ==========================================================
    // sticky flags, write one to clear, a same-cycle event wins
    assign flag_set = {ovf_pulse, match & active}; // [RULE_08]
    assign flag_clr = (wr_go && WB_ADR_I == srpsw_pkg::ADR_FLAG && WB_SEL_I[0]
        && WB_SEL_I[1]) ? WB_DAT_I[8:0] : 9'h000;

    always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            match_irq_flag <= 9'h000;
        end else begin
            match_irq_flag <= (match_irq_flag & ~flag_clr) | flag_set; // [RULE_08]
        end
    end

    // ==========================================================
    // phase shifter, reloaded by the overflow request
    srpsw_phase u_phase (
        .clk_i(SYS_CLK_I),
        .rst_i(SYS_RST_I),
        .enable_i(phase_shift_enable),
        .reload_i(ovf_pulse), // [RULE_14]
        .divisor_i(phase_divisor),
        .range_i(phase_pin_range),
        .step_o(step),
        .part_o(part)
    );

    // ==========================================================
    // channels: per-channel registers, generator and pin enable
    for (genvar j = 0; j < srpsw_pkg::NCH; j++) begin : g_ch
        // a channel claimed by time measurement stays silent
        assign active[j] = function_enable_reg[j] && !function_select_reg[j]; // [RULE_09]

        always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
            if (SYS_RST_I) begin
                output_control[j] <= srpsw_pkg::OCTL_RESET;
                compare_value[j] <= srpsw_pkg::CMP_RESET;
                WAVEFORM_OE_O[j] <= 1'b0;
            end else begin
                WAVEFORM_OE_O[j] <= active[j]; // [RULE_07]
                if (wr_go && WB_ADR_I == srpsw_pkg::ADR_OCTL + 8'(j * 4)) begin
                    output_control[j] <= 5'(wmerge(32'(output_control[j]), WB_DAT_I,
                        WB_SEL_I)); // [RULE_20]
                end
                if (wr_go && WB_ADR_I == srpsw_pkg::ADR_CMP + 8'(j * 4)) begin
                    compare_value[j] <= 16'(wmerge(32'(compare_value[j]), WB_DAT_I, WB_SEL_I));
                end
            end
        end

        srpsw_chan #(.CH_ID(j)) u_ch (
            .clk_i(SYS_CLK_I),
            .rst_i(SYS_RST_I),
            .tmr(tmr),
            .active_i(active[j]),
            .mode_i(output_control[j][2:0]), // [RULE_20]
            .ivl_i(output_control[j][srpsw_pkg::OCTL_IVL]),
            .inv_i(output_control[j][srpsw_pkg::OCTL_INV]),
            .cmp_i(compare_value[j]),
            .partner_match_i((j % 2 == 0) ? match[(j + 1) % srpsw_pkg::NCH] : 1'b0), // [RULE_23]
            .phase_part_i(part[j]),
            .phase_step_i(step[j]),
            .match_o(match[j]),
            .pin_o(WAVEFORM_PIN_O[j])
        );
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (SYS_RST_I);

    chk_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack held too long");
    chk_ack_timing: assert property (req && !WB_ACK_O |=> WB_ACK_O) else $error("ack late");
    chk_bit9_wrap: assert property (bit9_reset_option && wrap9 && !cmp0_hit // [RULE_18]
        |=> count == srpsw_pkg::TMR_ZERO) else $error("bit 9 wrap missed");
    chk_free_run: assert property (timer_reset_select == srpsw_pkg::RST_FREE // [RULE_05]
        && !bit9_reset_option |=> count == 16'($past(count) + 16'h0001))
        else $error("free count broken");
    chk_ovf_irq: assert property (wrap9 && !overflow_irq_select |=> ovf_pulse ##1 !ovf_pulse) // [RULE_19]
        else $error("overflow request wrong");
    chk_flag_set: assert property ((match & active) != 8'h00 // [RULE_08]
        |=> (match_irq_flag[7:0] & $past(match & active)) == $past(match & active))
        else $error("match flag lost");
    chk_sr_block: assert property (timer_reset_select == srpsw_pkg::RST_CMP0 && active[0] // [RULE_06]
        && output_control[0][2:0] == srpsw_pkg::MODE_SR && !part[0]
        && $past(active[0]) && $stable(output_control[0])
        |=> $stable(WAVEFORM_PIN_O[0])) else $error("sr ran on channel 0");
endmodule // srpsw_top

// ### verification/srpsw_load.sv
// Purpose: load on one waveform pin, measures high pulse widths
// Assumes: pin is a registered level sampled on the count clock
// Notes: width_o holds the length of the last finished high pulse
`timescale 1ns/1ns
module srpsw_load (
    input wire logic clk_i,
    input wire logic pin_i,
    output int width_o
);
    int run = 0;
    // count high cycles, latch the total when the pin falls
    always @(posedge clk_i) begin
        if (pin_i) begin
            run <= run + 1;
        end else begin
            if (run != 0) width_o <= run;
            run <= 0;
        end
    end
    initial width_o = 0;
endmodule // srpsw_load

// ### verification/srpsw_top_tb.sv
// Purpose: self-checking bench for the waveform generator
// Assumes: timer count equals cycles since reset release until the bit-9 reset in t_phase at 0x400
// Notes: one setup, levels sampled on falling edges with margin
`timescale 1ns/1ns
module srpsw_top_tb;
    logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, ack;
    logic [7:0] adr = 8'h00, pin, oe;
    logic [3:0] sel = 4'hF;
    logic [31:0] wdat = 32'h0000_0000, rdat, q;
    int w2, t = 0, error_cnt = 0, n_tests = 0;
    always #50 clk = ~clk;
    // local copy of the timer, to time the level checks
    always @(posedge clk) t <= rst ? 0 : t + 1;
    srpsw_top dut (.SYS_CLK_I(clk), .SYS_RST_I(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
        .WB_ACK_O(ack), .WAVEFORM_PIN_O(pin), .WAVEFORM_OE_O(oe));
    srpsw_load load (.clk_i(clk), .pin_i(pin[2]), .width_o(w2));
    // ==========================================================
    // helpers
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            error_cnt++;
            $display("CHECK FAILED %0t saw %h want %h", $time, s, e);
        end
    endtask
    // classic cycle, held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        @(posedge clk);
        while (ack !== 1'b1 && k < 20) begin
            @(posedge clk);
            k++;
        end
        // a slave that never answers counts against the run
        if (k >= 20) error_cnt++;
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic at(input int c);
        while (t < c) @(posedge clk);
        @(negedge clk);
    endtask
    // ==========================================================
    // scenarios
    task automatic t_setup;
        logic [15:0] cv [8] = '{16'h0150, 16'h0160, 16'h0100, 16'h0110,
            16'h0180, 16'h0100, 16'h0120, 16'h0130};
        logic [4:0] mv [8] = '{5'h0A, 5'h07, 5'h02, 5'h07, 5'h02, 5'h07, 5'h12, 5'h07};
        for (int j = 0; j < 8; j++) begin
            wb(1'b1, srpsw_pkg::ADR_CMP + 8'(4 * j), {16'h0000, cv[j]});
            wb(1'b1, srpsw_pkg::ADR_OCTL + 8'(4 * j), {27'h000_0000, mv[j]});
        end
        wb(1'b1, srpsw_pkg::ADR_FEN, 32'h0000_007F); // function select left at 0
        at(16'h0080);
        chk(32'(pin[0]), 32'h0000_0001);
        chk(32'(oe), 32'h0000_007F);
    endtask
    task automatic t_sr;
        at(16'h0108);
        chk(32'(pin[2]), 32'h0000_0001);
        at(16'h0118);
        chk(32'(pin[2]), 32'h0000_0000);
        at(16'h0128);
        chk(32'(pin[6]), 32'h0000_0000);
        at(16'h0138);
        chk(32'(pin[6]), 32'h0000_0001);
        at(16'h0168);
        chk(32'(pin[0]), 32'h0000_0000);
        at(16'h01A0);
        chk(32'(pin[4]), 32'h0000_0001);
        chk(32'(pin[5]), 32'h0000_0000);
        chk(32'(w2), 32'h0000_0010);
    endtask
    task automatic t_flags;
        wb(1'b0, srpsw_pkg::ADR_FLAG, 32'h0000_0000);
        chk(q & 32'h0000_00FF, 32'h0000_007F);
        wb(1'b0, 8'hFC, 32'h0000_0000);
        chk(q, 32'h0000_0000);
    endtask
    task automatic t_stop;
        wb(1'b1, srpsw_pkg::ADR_FEN, 32'h0000_0000); // low pins only by release
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk(32'(pin), 32'h0000_0000);
        chk(32'(oe), 32'h0000_0000);
    endtask
    // phase shift on channels 0-4, divide by 16, bit-9 frame from count 0x400
    task automatic t_phase;
        wb(1'b1, srpsw_pkg::ADR_BTC, 32'h0000_0008);
        for (int j = 0; j < 5; j++) begin
            wb(1'b1, srpsw_pkg::ADR_CMP + 8'(4 * j), 32'h0000_0300);
            wb(1'b1, srpsw_pkg::ADR_OCTL + 8'(4 * j), 32'h0000_0010);
        end
        wb(1'b1, srpsw_pkg::ADR_PSC, 32'h0000_0F01);
        wb(1'b1, srpsw_pkg::ADR_FEN, 32'h0000_001F);
        at(16'h0308);
        chk(32'(pin), 32'h0000_0000);
        at(16'h0428);
        chk(32'(pin[1:0]), 32'h0000_0003);
        chk(32'(pin[2]), 32'h0000_0000);
        at(16'h0460);
        chk(32'(pin), 32'h0000_001F);
        wb(1'b0, srpsw_pkg::ADR_FLAG, 32'h0000_0000);
        chk(q & 32'h0000_0100, 32'h0000_0100);
        wb(1'b0, srpsw_pkg::ADR_CNT, 32'h0000_0000);
        chk(32'(q[15:10]), 32'h0000_0000);
    endtask
    task automatic close_out;
        if (error_cnt == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // ==========================================================
    // main sequence and watchdog
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_setup();
        t_sr();
        t_flags();
        t_stop();
        t_phase();
        close_out();
    end
    // the whole run needs about 1200 cycles, allow 4000
    initial begin
        #400000;
        error_cnt++;
        close_out();
    end
endmodule // srpsw_top_tb
